// [src/bit_mask_gen.v]
`include "instr_decode_map.vh"

// one-hot set/clear masks for bit operations
module bit_mask_gen (
  input wire [2:0] bit_sel,
  output wire [7:0] bit_onehot
);
  // ----------------------------------------
  // per-bit select
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      // widen the select instead of slicing the loop index, which not every front end allows
      assign bit_onehot[i] = ({29'h0000000, bit_sel} == i);
    end
  endgenerate
endmodule // bit_mask_gen

// [src/instr_decode_map.vh]
`ifndef INSTR_DECODE_MAP_VH
`define INSTR_DECODE_MAP_VH

// ----------------------------------------
// word layout
// ----------------------------------------
`define IW_WIDTH 14
`define IW_CLASS_HI 13
`define IW_CLASS_LO 12
`define IW_D_BIT 7
`define IW_F_HI 6
`define IW_B_HI 9
`define IW_B_LO 7
`define IW_K8_HI 7
`define IW_K11_HI 10
`define IW_CALL_GOTO_BIT 11

// ----------------------------------------
// classes and fixed words
// ----------------------------------------
`define CLS_BYTE 2'h0
`define CLS_BIT 2'h1
`define CLS_JUMP 2'h2
`define CLS_LIT 2'h3
`define W_SLEEP 14'h0063
`define W_CLRWDT 14'h0064
`define W_RETFIE 14'h0009
`define W_RETURN 14'h0008

// ----------------------------------------
// timing
// ----------------------------------------
`define Q_PHASES 4
`define Q_LAST 2'h3

// ----------------------------------------
// operation codes
// ----------------------------------------
`define OP_NOP 6'h00
`define OP_MOVWF 6'h01
`define OP_CLRW 6'h02
`define OP_CLRF 6'h03
`define OP_SUBWF 6'h04
`define OP_DECF 6'h05
`define OP_IORWF 6'h06
`define OP_ANDWF 6'h07
`define OP_XORWF 6'h08
`define OP_ADDWF 6'h09
`define OP_MOVF 6'h0A
`define OP_COMF 6'h0B
`define OP_INCF 6'h0C
`define OP_DECFSZ 6'h0D
`define OP_RRF 6'h0E
`define OP_RLF 6'h0F
`define OP_SWAPF 6'h10
`define OP_INCFSZ 6'h11
`define OP_BCF 6'h12
`define OP_BSF 6'h13
`define OP_BTFSC 6'h14
`define OP_BTFSS 6'h15
`define OP_CALL 6'h16
`define OP_GOTO 6'h17
`define OP_MOVLW 6'h18
`define OP_RETLW 6'h19
`define OP_IORLW 6'h1A
`define OP_ANDLW 6'h1B
`define OP_XORLW 6'h1C
`define OP_SUBLW 6'h1D
`define OP_ADDLW 6'h1E
`define OP_RETFIE 6'h1F
`define OP_RETURN 6'h20
`define OP_SLEEP 6'h21
`define OP_CLRWDT 6'h22
`define OP_ILLEGAL 6'h3F

`endif

// [src/instruction_field_decoder.v]
`include "instr_decode_map.vh"

// decodes fetched words and sequences the four-phase instruction cycle
module instruction_field_decoder (
  input wire ref_clk,
  input wire rst_b,
  input wire [13:0] instr_word,
  input wire cond_true,
  input wire [7:0] file_rd_data,
  output reg [5:0] op_code_q,
  output reg [1:0] op_class_q,
  output reg [6:0] file_addr_q,
  output reg dest_file_q,
  output reg dest_acc_q,
  output reg [2:0] bit_sel_q,
  output reg [7:0] lit8_q,
  output reg [10:0] lit11_q,
  output reg [7:0] bit_result_q,
  output reg sleep_q,
  output reg clr_timeout_q,
  output reg flush_q,
  output reg [1:0] q_phase_q,
  output wire fetch_strobe,
  output wire exec_strobe
);
  // ----------------------------------------
  // phase counter
  // ----------------------------------------
  reg [1:0] q_phase_d;
  reg flush_d;
  reg [5:0] op_d;
  wire [7:0] bit_onehot;
  wire [1:0] cls;
  wire changes_pc;
  wire is_skip;
  wire has_dest;
  reg dest_file_d;
  reg dest_acc_d;
  reg [7:0] bit_result_d;

  assign cls = instr_word[`IW_CLASS_HI:`IW_CLASS_LO];
  assign fetch_strobe = (q_phase_q == `Q_LAST); // word latched at end of cycle
  assign exec_strobe = (q_phase_q == 2'h0) & ~flush_q;

  // four oscillator periods per instruction cycle
  always @* begin
    q_phase_d = q_phase_q + 2'h1; // wraps after four
  end

  // ----------------------------------------
  // opcode decode
  // ----------------------------------------
  // x positions are simply never compared
  always @* begin
    op_d = `OP_ILLEGAL;
    case (cls)
      `CLS_BYTE: begin
        case (instr_word[11:8])
          4'h0: begin
            if (instr_word[7]) begin
              op_d = `OP_MOVWF;
            end else if (instr_word == `W_SLEEP) begin
              op_d = `OP_SLEEP;
            end else if (instr_word == `W_CLRWDT) begin
              op_d = `OP_CLRWDT;
            end else if (instr_word == `W_RETFIE) begin
              op_d = `OP_RETFIE;
            end else if (instr_word == `W_RETURN) begin
              op_d = `OP_RETURN;
            end else if (instr_word[4:0] == 5'h00 && instr_word[7] == 1'b0) begin
              op_d = `OP_NOP; // bits 6:5 ignored
            end else begin
              op_d = `OP_ILLEGAL;
            end
          end
          4'h1: op_d = instr_word[7] ? `OP_CLRF : `OP_CLRW;
          4'h2: op_d = `OP_SUBWF;
          4'h3: op_d = `OP_DECF;
          4'h4: op_d = `OP_IORWF;
          4'h5: op_d = `OP_ANDWF;
          4'h6: op_d = `OP_XORWF;
          4'h7: op_d = `OP_ADDWF;
          4'h8: op_d = `OP_MOVF;
          4'h9: op_d = `OP_COMF;
          4'hA: op_d = `OP_INCF;
          4'hB: op_d = `OP_DECFSZ;
          4'hC: op_d = `OP_RRF;
          4'hD: op_d = `OP_RLF;
          4'hE: op_d = `OP_SWAPF;
          default: op_d = `OP_INCFSZ;
        endcase
      end
      `CLS_BIT: begin
        case (instr_word[11:10])
          2'h0: op_d = `OP_BCF;
          2'h1: op_d = `OP_BSF;
          2'h2: op_d = `OP_BTFSC;
          default: op_d = `OP_BTFSS;
        endcase
      end
      `CLS_JUMP: op_d = instr_word[`IW_CALL_GOTO_BIT] ? `OP_GOTO : `OP_CALL;
      default: begin
        casez (instr_word[11:8])
          4'b00??: op_d = `OP_MOVLW;
          4'b01??: op_d = `OP_RETLW;
          4'b1000: op_d = `OP_IORLW;
          4'b1001: op_d = `OP_ANDLW;
          4'b1010: op_d = `OP_XORLW;
          4'b110?: op_d = `OP_SUBLW;
          4'b111?: op_d = `OP_ADDLW;
          default: op_d = `OP_ILLEGAL;
        endcase
      end
    endcase
  end

  // ----------------------------------------
  // second-cycle decision
  // ----------------------------------------
  // pc writes always take two cycles; skips only when the test holds
  assign changes_pc = (op_d == `OP_CALL) | (op_d == `OP_GOTO) | (op_d == `OP_RETLW) |
                      (op_d == `OP_RETFIE) | (op_d == `OP_RETURN);
  assign is_skip = (op_d == `OP_DECFSZ) | (op_d == `OP_INCFSZ) |
                   (op_d == `OP_BTFSC) | (op_d == `OP_BTFSS);

  always @* begin
    flush_d = changes_pc | (is_skip & cond_true);
  end

  bit_mask_gen u_mask (
    .bit_sel(instr_word[`IW_B_HI:`IW_B_LO]),
    .bit_onehot(bit_onehot)
  );

  // ----------------------------------------
  // destination and bit result
  // ----------------------------------------
  // control words share the byte class but carry no d field to route
  assign has_dest = (cls == `CLS_BYTE) & (op_d != `OP_ILLEGAL) & (op_d != `OP_NOP) &
                    (op_d != `OP_SLEEP) & (op_d != `OP_CLRWDT) & (op_d != `OP_RETFIE) &
                    (op_d != `OP_RETURN);

  // d = 0 keeps the result in the accumulator, d = 1 writes it back
  always @* begin
    dest_file_d = has_dest & instr_word[`IW_D_BIT];
    dest_acc_d = has_dest & ~instr_word[`IW_D_BIT];
  end

  // read-modify-write touches one bit only; other ops pass the byte through
  always @* begin
    if (op_d == `OP_BSF) begin
      bit_result_d = file_rd_data | bit_onehot;
    end else if (op_d == `OP_BCF) begin
      bit_result_d = file_rd_data & ~bit_onehot;
    end else begin
      bit_result_d = file_rd_data;
    end
  end

  // ----------------------------------------
  // phase register
  // ----------------------------------------
  // free running: the core never stalls mid-cycle, so no enable is needed
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_phase_q <= 2'h0;
    end else begin
      q_phase_q <= q_phase_d;
    end
  end

  // ----------------------------------------
  // field registers
  // ----------------------------------------
  // fields load at the end of the fetch cycle; a flushed slot decodes as nop
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      op_code_q <= `OP_NOP;
      op_class_q <= `CLS_BYTE;
      file_addr_q <= 7'h00;
      dest_file_q <= 1'b0;
      dest_acc_q <= 1'b0;
      bit_sel_q <= 3'h0;
      lit8_q <= 8'h00;
      lit11_q <= 11'h000;
      bit_result_q <= 8'h00;
    end else if (fetch_strobe) begin
      if (flush_q) begin
        // the fetched word is discarded: second cycle runs as a nop
        op_code_q <= `OP_NOP;
        op_class_q <= `CLS_BYTE;
        dest_file_q <= 1'b0;
        dest_acc_q <= 1'b0;
      end else begin
        op_code_q <= op_d;
        op_class_q <= cls;
        file_addr_q <= instr_word[`IW_F_HI:0];
        dest_file_q <= dest_file_d;
        dest_acc_q <= dest_acc_d;
        bit_sel_q <= instr_word[`IW_B_HI:`IW_B_LO];
        lit8_q <= instr_word[`IW_K8_HI:0];
        lit11_q <= instr_word[`IW_K11_HI:0];
        bit_result_q <= bit_result_d;
      end
    end
  end

  // ----------------------------------------
  // control flags
  // ----------------------------------------
  // flags last one instruction cycle; a flushed slot drops them so a discarded word never acts
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_q <= 1'b0;
      clr_timeout_q <= 1'b0;
      flush_q <= 1'b0;
    end else if (fetch_strobe) begin
      if (flush_q) begin
        sleep_q <= 1'b0;
        clr_timeout_q <= 1'b0;
        flush_q <= 1'b0; // one nop slot per taken skip or branch
      end else begin
        sleep_q <= (op_d == `OP_SLEEP); // core clears power-down, sets time-out
        clr_timeout_q <= (op_d == `OP_SLEEP) | (op_d == `OP_CLRWDT);
        flush_q <= flush_d;
      end
    end
  end
endmodule // instruction_field_decoder

// [testbench/instr_dec_props.sv]
`include "instr_decode_map.vh"

// ----------------------------------------
// decoder port checker
// ----------------------------------------
module instr_dec_props (
  input wire ref_clk,
  input wire rst_b,
  input wire [13:0] instr_word,
  input wire [7:0] file_rd_data,
  input wire [5:0] op_code_q,
  input wire [6:0] file_addr_q,
  input wire dest_file_q,
  input wire dest_acc_q,
  input wire [2:0] bit_sel_q,
  input wire [10:0] lit11_q,
  input wire [7:0] bit_result_q,
  input wire sleep_q,
  input wire clr_timeout_q,
  input wire flush_q,
  input wire [1:0] q_phase_q,
  input wire fetch_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // a word is taken only when the slot is not flushed
  wire take = fetch_strobe && !flush_q;
  sequence quiet3;
    !fetch_strobe [*3];
  endsequence
  chk_cycle_four: assert property (fetch_strobe |=> quiet3 ##1 fetch_strobe)
    else $error("fetch spacing not four periods");
  chk_fetch_phase: assert property (fetch_strobe |-> q_phase_q == 2'h3
    ##1 q_phase_q == 2'h0 ##1 q_phase_q == 2'h1)
    else $error("phase counter not stepping after fetch");
  chk_hold_fields: assert property (!fetch_strobe |=> $stable({op_code_q, file_addr_q, lit11_q}))
    else $error("decoded fields moved mid cycle");
  chk_operand_fields: assert property (take |=> file_addr_q == $past(instr_word[6:0])
    && bit_sel_q == $past(instr_word[9:7]) && lit11_q == $past(instr_word[10:0]))
    else $error("operand field mismatch");
  chk_dest_select: assert property (take && instr_word[13:12] == 2'h0 && instr_word[11:8] >= 4'h2
    |=> dest_file_q == $past(instr_word[7]) && dest_acc_q == !$past(instr_word[7]))
    else $error("destination select wrong");
  chk_sleep_word: assert property (take && instr_word == `W_SLEEP
    |=> sleep_q && clr_timeout_q && op_code_q == `OP_SLEEP)
    else $error("standby word not decoded");
  chk_bit_set: assert property (take && instr_word[13:10] == 4'h5
    |=> bit_result_q == ($past(file_rd_data) | (8'h01 << $past(instr_word[9:7]))))
    else $error("bit set result wrong");
  chk_flush_nop: assert property (fetch_strobe && flush_q |=> op_code_q == `OP_NOP && !flush_q)
    else $error("flushed slot not a no-op");
  chk_jump_flush: assert property (take && instr_word[13:12] == `CLS_JUMP |=> flush_q)
    else $error("jump did not flush");
endmodule // instr_dec_props

bind instruction_field_decoder instr_dec_props u_props (.*);

// [testbench/test_instruction_field_decoder.sv]
`include "instr_decode_map.vh"

module test_instruction_field_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic cond_true = 1'b0;
  logic [7:0] file_rd_data = 8'h00;
  wire [5:0] op_code_q;
  wire [1:0] op_class_q, q_phase_q;
  wire [6:0] file_addr_q;
  wire [2:0] bit_sel_q;
  wire [7:0] lit8_q, bit_result_q;
  wire [10:0] lit11_q;
  wire dest_file_q, dest_acc_q, sleep_q, clr_timeout_q, flush_q, fetch_strobe, exec_strobe;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  // rows: word, skip result, expected op, expected flush; x bits set on purpose
  logic [21:0] rows [14] = '{{14'h07FF, 1'b0, `OP_ADDWF, 1'b0}, {14'h0700, 1'b1, `OP_ADDWF, 1'b0},
    {14'h0B85, 1'b1, `OP_DECFSZ, 1'b1}, {14'h0B85, 1'b0, `OP_DECFSZ, 1'b0},
    {14'h017F, 1'b0, `OP_CLRW, 1'b0}, {14'h0060, 1'b0, `OP_NOP, 1'b0},
    {14'h1C00, 1'b1, `OP_BTFSS, 1'b1}, {14'h1800, 1'b0, `OP_BTFSC, 1'b0},
    {14'h2ABC, 1'b0, `OP_GOTO, 1'b1}, {14'h2123, 1'b0, `OP_CALL, 1'b1},
    {14'h3F5A, 1'b0, `OP_ADDLW, 1'b0}, {14'h3355, 1'b0, `OP_MOVLW, 1'b0},
    {14'h0009, 1'b0, `OP_RETFIE, 1'b1}, {14'h3455, 1'b0, `OP_RETLW, 1'b1}};

  instruction_field_decoder dut (.*);

  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // generous: the whole run needs about 113 cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input string name, input logic [13:0] seen, input logic [13:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // word goes up one edge before the fetch edge, checked after it
  task automatic issue(input logic [13:0] w, input logic c, input logic [7:0] fd);
    @(negedge ref_clk);
    while (q_phase_q !== 2'h2) @(negedge ref_clk);
    @(posedge ref_clk);
    instr_word <= w;
    cond_true <= c;
    file_rd_data <= fd;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      issue(rows[i][21:8], rows[i][7], 8'h00);
      chk("op", 14'(op_code_q), 14'(rows[i][6:1]));
      chk("flush", 14'(flush_q), 14'(rows[i][0]));
      chk("file", 14'(file_addr_q), 14'(rows[i][14:8]));
      chk("lit8", 14'(lit8_q), 14'(rows[i][15:8]));
      chk("class", 14'(op_class_q), 14'(rows[i][21:20]));
      chk("exec", 14'(exec_strobe), 14'(!rows[i][0]));
      if (rows[i][0]) begin
        issue(14'h3FFF, 1'b0, 8'h00);
        chk("slot", 14'(op_code_q), 14'(`OP_NOP));
        chk("slot exec", 14'(exec_strobe), 14'h0001);
      end
    end
    issue(14'h0E80, 1'b0, 8'h00);
    chk("dest", 14'({dest_file_q, dest_acc_q}), 14'h0002);
    issue(14'h0E00, 1'b0, 8'h00);
    chk("dest", 14'({dest_file_q, dest_acc_q}), 14'h0001);
    issue(14'h1785, 1'b0, 8'h5A);
    chk("bset", 14'(bit_result_q), 14'h00DA);
    chk("bsel", 14'(bit_sel_q), 14'h0007);
    issue(14'h1000, 1'b0, 8'hA5);
    chk("bclr", 14'(bit_result_q), 14'h00A4);
    issue(14'h0063, 1'b0, 8'h00);
    chk("sleep", 14'({sleep_q, clr_timeout_q}), 14'h0003);
    issue(14'h2FFF, 1'b0, 8'h00);
    chk("lit11", 14'(lit11_q), 14'h07FF);
    // mid-run reset must clear the decoded op
    @(posedge ref_clk);
    rst_b <= 1'b0;
    @(negedge ref_clk);
    chk("rst op", 14'({op_code_q, q_phase_q}), 14'h0000);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    issue(14'h0064, 1'b0, 8'h00);
    chk("wdt", 14'({sleep_q, clr_timeout_q}), 14'h0001);
    results();
  end
endmodule // test_instruction_field_decoder
